// ===== pkg/aopg_defines.svh
// Constants for the auxiliary output pattern generator.
// Assumes a 200 MHz core clock; all counts are in 5 ns cycles.
`ifndef AOPG_DEFINES_SVH
`define AOPG_DEFINES_SVH

`define AOPG_CLK_PERIOD_PS   32'd5000
// Times in ps as given; counts derived (least round up, longest round down)
`define AOPG_T_8NS_PS        32'd8000
`define AOPG_T_4NS_PS        32'd4000
`define AOPG_T_PER_MAX_PS    64'd524000000
`define AOPG_T_BIT_MAX_PS    64'd260000000
`define AOPG_CYC_8NS         (((`AOPG_T_8NS_PS) + (`AOPG_CLK_PERIOD_PS) - 32'd1) / (`AOPG_CLK_PERIOD_PS))
`define AOPG_CYC_4NS         (((`AOPG_T_4NS_PS) + (`AOPG_CLK_PERIOD_PS) - 32'd1) / (`AOPG_CLK_PERIOD_PS))
`define AOPG_CYC_PER_MAX     ((`AOPG_T_PER_MAX_PS) / 64'd5000)
`define AOPG_CYC_BIT_MAX     ((`AOPG_T_BIT_MAX_PS) / 64'd5000)

// Register offsets
`define AOPG_REG_CTRL        4'h0
`define AOPG_REG_PERIOD      4'h1
`define AOPG_REG_WIDTH       4'h2
`define AOPG_REG_DELAY       4'h3
`define AOPG_REG_BITTIME     4'h4
`define AOPG_REG_STATUS      4'h5
`define AOPG_REG_PATTERN     4'h6

// Control field positions
`define AOPG_CTRL_MODE_LSB   0
`define AOPG_CTRL_POL_BIT    3
`define AOPG_CTRL_TSRC_BIT   4
`define AOPG_CTRL_LEN_LSB    5
`define AOPG_CTRL_EN_BIT     7

// Reset values
`define AOPG_RST_PERIOD      32'd4
`define AOPG_RST_WIDTH       32'd2
`define AOPG_RST_BITTIME     32'd1

// Clock mode toggles every cycle: output pattern rate limited by 200 MHz core
`define AOPG_FIFO_DEPTH      32
`define AOPG_FIFO_AW         5

`endif

// ===== pkg/aopg_pkg.sv
// Types for the auxiliary output pattern generator.
// Constants live in aopg_defines.svh.
package aopg_pkg;
   typedef enum logic [2:0] {
      AOPG_MODE_PULSE,
      AOPG_MODE_NRZ,
      AOPG_MODE_RZ,
      AOPG_MODE_CLOCK,
      AOPG_MODE_TRIG
   } aopg_mode_t;

   typedef enum logic [1:0] {
      AOPG_LEN_7,
      AOPG_LEN_10,
      AOPG_LEN_11,
      AOPG_LEN_15
   } aopg_len_t;
endpackage : aopg_pkg

// ===== rtl/aopg_gen.sv
// Auxiliary output pattern generator: pulse, NRZ, RZ, clock, trigger-out.
// Assumes a 200 MHz clock, register port from same-clock software logic.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "aopg_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Small synchronous FIFO between the bit generator and the output stage
module aopg_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = `AOPG_FIFO_DEPTH,
   parameter int AW    = `AOPG_FIFO_AW
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             flush_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   output logic [WIDTH-1:0]      rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             do_wr;
   logic             do_rd;

   always_comb begin
      wr_ready_out = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
      rd_valid_out = wr_ptr != rd_ptr;
      rd_data_out  = mem[rd_ptr[AW-1:0]];
      do_wr        = wr_valid_in && wr_ready_out;
      do_rd        = rd_valid_out && rd_ready_in;
      next_wr_ptr  = flush_in ? '0 : wr_ptr + (AW+1)'(do_wr);
      next_rd_ptr  = flush_in ? '0 : rd_ptr + (AW+1)'(do_rd);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // Storage has no reset; pointers make unwritten words unreachable
   always_ff @(posedge clk_in) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= wr_data_in;
      end
   end
endmodule : aopg_fifo

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Exactly one waveform type drives the output at a time.
// - Pulse period programmable from 8 ns to 524 us.
// - Pulse width from 8 ns up to period minus 8 ns.
// - Pulse start delayed after trigger by zero to period minus 8 ns.
// - Pulse polarity selectable; inverted setting flips the active level.
// - NRZ bit time programmable from 4 ns to 260 us.
// - NRZ stream delayed after trigger by zero to bit time minus 8 ns.
// - NRZ pattern length 2^7, 2^10, 2^11 or 2^15 minus one.
// - NRZ polarity selectable; inverted setting inverts the data.
// - Stream trigger source selectable: data clock or pattern start.
// - RZ bit time programmable from 8 ns to 260 us.
// - RZ stream delayed after trigger by zero to bit time minus 8 ns.
// - RZ pattern length selectable among four, polarity selectable.
// - Clock mode outputs a clock synchronous with the internal clock.
// - Trigger-out pulse follows internal trigger, active edge falling.
// - Trigger-out source switchable between clock and pattern generator.
// - Auxiliary input is ignored entirely.
module aopg_gen (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Register port
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic [31:0]      reg_rdata_out,
   // Auxiliary connectors
   input  wire logic        aux_in,
   output logic             aux_out,
   output logic             trig_out
);
   // Control and setting registers
   logic [7:0]  ctrl;
   logic [31:0] period_set;
   logic [31:0] width_set;
   logic [31:0] delay_set;
   logic [31:0] bit_set;
   logic [7:0]  next_ctrl;
   logic [31:0] next_period_set;
   logic [31:0] next_width_set;
   logic [31:0] next_delay_set;
   logic [31:0] next_bit_set;
   logic [31:0] next_rdata;

   // Active (clamped) settings, loaded at period boundary (bit time at pattern start) or while disabled
   logic [31:0] period_act;
   logic [31:0] width_act;
   logic [31:0] delay_act;
   logic [31:0] bit_act;
   logic [31:0] next_period_act;
   logic [31:0] next_width_act;
   logic [31:0] next_delay_act;
   logic [31:0] next_bit_act;

   // Timing state
   logic [31:0] cyc_cnt;
   logic [31:0] next_cyc_cnt;
   logic [31:0] bit_cnt;
   logic [31:0] next_bit_cnt;
   logic [14:0] lfsr;
   logic [14:0] next_lfsr;
   logic [14:0] pat_cnt;
   logic [14:0] next_pat_cnt;
   logic        clk_tog;
   logic        next_clk_tog;
   logic        aux_q;
   logic        trig_q;
   logic        next_aux_q;
   logic        next_trig_q;

   aopg_pkg::aopg_mode_t mode;
   aopg_pkg::aopg_len_t  len_sel;
   logic                 pol_inv;
   logic                 tsrc_pat;
   logic                 gen_en;
   logic                 boundary;
   logic                 bit_tick;
   logic                 pat_start;
   logic                 fb;
   logic [14:0]          pat_last;
   logic [31:0]          min_bit;
   logic                 stream_mode;

   // FIFO wiring
   logic fifo_wr_ready;
   logic fifo_rd_data;
   logic fifo_rd_valid;
   logic fifo_rd_ready;
   logic fifo_flush;

   always_comb begin
      mode     = aopg_pkg::aopg_mode_t'(ctrl[`AOPG_CTRL_MODE_LSB +: 3]);
      len_sel  = aopg_pkg::aopg_len_t'(ctrl[`AOPG_CTRL_LEN_LSB +: 2]);
      pol_inv  = ctrl[`AOPG_CTRL_POL_BIT];
      tsrc_pat = ctrl[`AOPG_CTRL_TSRC_BIT];
      gen_en   = ctrl[`AOPG_CTRL_EN_BIT];
      stream_mode = (mode == aopg_pkg::AOPG_MODE_NRZ) || (mode == aopg_pkg::AOPG_MODE_RZ);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port
   always_comb begin
      next_ctrl       = ctrl;
      next_period_set = period_set;
      next_width_set  = width_set;
      next_delay_set  = delay_set;
      next_bit_set    = bit_set;
      if (reg_wr_in) begin
         if (reg_addr_in == `AOPG_REG_CTRL) begin
            next_ctrl = reg_wdata_in[7:0];
         end else if (reg_addr_in == `AOPG_REG_PERIOD) begin
            next_period_set = reg_wdata_in;
         end else if (reg_addr_in == `AOPG_REG_WIDTH) begin
            next_width_set = reg_wdata_in;
         end else if (reg_addr_in == `AOPG_REG_DELAY) begin
            next_delay_set = reg_wdata_in;
         end else if (reg_addr_in == `AOPG_REG_BITTIME) begin
            next_bit_set = reg_wdata_in;
         end
      end
      next_rdata = '0;
      if (reg_rd_in) begin
         if (reg_addr_in == `AOPG_REG_CTRL) begin
            next_rdata = {24'h000000, ctrl};
         end else if (reg_addr_in == `AOPG_REG_PERIOD) begin
            next_rdata = period_set;
         end else if (reg_addr_in == `AOPG_REG_WIDTH) begin
            next_rdata = width_set;
         end else if (reg_addr_in == `AOPG_REG_DELAY) begin
            next_rdata = delay_set;
         end else if (reg_addr_in == `AOPG_REG_BITTIME) begin
            next_rdata = bit_set;
         end else if (reg_addr_in == `AOPG_REG_STATUS) begin
            next_rdata = {29'h0000000, fifo_rd_valid, trig_q, aux_q};
         end else if (reg_addr_in == `AOPG_REG_PATTERN) begin
            next_rdata = {17'h0000, lfsr};
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl          <= 8'h00;
         period_set    <= `AOPG_RST_PERIOD;
         width_set     <= `AOPG_RST_WIDTH;
         delay_set     <= 32'h00000000;
         bit_set       <= `AOPG_RST_BITTIME;
         reg_rdata_out <= 32'h00000000;
      end else begin
         ctrl          <= next_ctrl;
         period_set    <= next_period_set;
         width_set     <= next_width_set;
         delay_set     <= next_delay_set;
         bit_set       <= next_bit_set;
         reg_rdata_out <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clamping and period timer
   always_comb begin
      boundary  = (cyc_cnt >= period_act - 32'd1);
      bit_tick  = (bit_cnt >= bit_act - 32'd1);
      pat_last  = (len_sel == aopg_pkg::AOPG_LEN_7)  ? 15'h007e :
                  (len_sel == aopg_pkg::AOPG_LEN_10) ? 15'h03fe :
                  (len_sel == aopg_pkg::AOPG_LEN_11) ? 15'h07fe : 15'h7ffe;
      // At or past the end, so a shorter length chosen mid-run still restarts
      pat_start = bit_tick && (pat_cnt >= pat_last);
      min_bit   = (mode == aopg_pkg::AOPG_MODE_RZ) ? 32'(`AOPG_CYC_8NS)
                                                  : 32'(`AOPG_CYC_4NS);

      next_period_act = period_act;
      next_width_act  = width_act;
      next_delay_act  = delay_act;
      next_bit_act    = bit_act;
      // Settings load only at a boundary or while disabled so a period never runs half-old
      if (boundary || !gen_en) begin
         next_period_act = (period_set < 32'(`AOPG_CYC_8NS)) ? 32'(`AOPG_CYC_8NS) :
                           (period_set > 32'(`AOPG_CYC_PER_MAX)) ?
                           32'(`AOPG_CYC_PER_MAX) : period_set;
         next_width_act  = (width_set < 32'(`AOPG_CYC_8NS)) ? 32'(`AOPG_CYC_8NS) :
                           (width_set > next_period_act - 32'(`AOPG_CYC_8NS)) ?
                           next_period_act - 32'(`AOPG_CYC_8NS) : width_set;
         // Streams clamp delay to the bit time below, not to the period
         if (!stream_mode) begin
            next_delay_act = (delay_set > next_period_act - 32'(`AOPG_CYC_8NS)) ?
                             next_period_act - 32'(`AOPG_CYC_8NS) : delay_set;
         end
      end
      if ((bit_tick && pat_start) || !gen_en) begin
         next_bit_act = (bit_set < min_bit) ? min_bit :
                        (bit_set > 32'(`AOPG_CYC_BIT_MAX)) ?
                        32'(`AOPG_CYC_BIT_MAX) : bit_set;
         if (stream_mode) begin
            next_delay_act = (delay_set > next_bit_act - 32'(`AOPG_CYC_8NS)) ?
                             next_bit_act - 32'(`AOPG_CYC_8NS) : delay_set;
            if (next_bit_act < 32'(`AOPG_CYC_8NS)) begin
               next_delay_act = 32'h00000000;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pattern generator: Fibonacci LFSRs, taps for maximal length
   always_comb begin
      case (len_sel)
         aopg_pkg::AOPG_LEN_7:  fb = lfsr[6] ^ lfsr[5];
         aopg_pkg::AOPG_LEN_10: fb = lfsr[9] ^ lfsr[6];
         aopg_pkg::AOPG_LEN_11: fb = lfsr[10] ^ lfsr[8];
         default:               fb = lfsr[14] ^ lfsr[13];
      endcase

      next_cyc_cnt = (boundary || !gen_en) ? 32'h00000000 : cyc_cnt + 32'd1;
      next_bit_cnt = (bit_tick || !gen_en) ? 32'h00000000 : bit_cnt + 32'd1;
      next_lfsr    = lfsr;
      next_pat_cnt = pat_cnt;
      if (!gen_en || (bit_tick && pat_start)) begin
         next_lfsr    = 15'h7fff;
         next_pat_cnt = 15'h0000;
      end else if (bit_tick && fifo_wr_ready) begin
         next_lfsr    = {lfsr[13:0], fb};
         next_pat_cnt = pat_cnt + 15'd1;
      end
      next_clk_tog = gen_en ? ~clk_tog : 1'b0;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         period_act <= `AOPG_RST_PERIOD;
         width_act  <= `AOPG_RST_WIDTH;
         delay_act  <= 32'h00000000;
         bit_act    <= `AOPG_RST_BITTIME;
         cyc_cnt    <= 32'h00000000;
         bit_cnt    <= 32'h00000000;
         lfsr       <= 15'h7fff;
         pat_cnt    <= 15'h0000;
         clk_tog    <= 1'b0;
      end else begin
         period_act <= next_period_act;
         width_act  <= next_width_act;
         delay_act  <= next_delay_act;
         bit_act    <= next_bit_act;
         cyc_cnt    <= next_cyc_cnt;
         bit_cnt    <= next_bit_cnt;
         lfsr       <= next_lfsr;
         pat_cnt    <= next_pat_cnt;
         clk_tog    <= next_clk_tog;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data buffer: bits wait here until their slot after the delay
   always_comb begin
      fifo_flush    = !gen_en || !stream_mode;
      fifo_rd_ready = stream_mode && (bit_cnt == delay_act);
   end

   aopg_fifo #(
      .WIDTH (1),
      .DEPTH (`AOPG_FIFO_DEPTH),
      .AW    (`AOPG_FIFO_AW)
   ) u_fifo (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .flush_in     (fifo_flush),
      .wr_data_in   (lfsr[0]),
      .wr_valid_in  (bit_tick && stream_mode),
      .wr_ready_out (fifo_wr_ready),
      .rd_data_out  (fifo_rd_data),
      .rd_valid_out (fifo_rd_valid),
      .rd_ready_in  (fifo_rd_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output selection; aux_in is never read on purpose
   logic rz_bit;
   logic nrz_bit;
   logic pulse_lvl;
   logic [31:0] pulse_ofs;
   logic cur_bit;
   logic next_cur_bit;
   logic trig_evt;

   always_comb begin
      // Pulse wraps past the period end when delay plus width is long
      pulse_ofs = (cyc_cnt >= delay_act) ? cyc_cnt - delay_act
                                         : cyc_cnt + period_act - delay_act;
      pulse_lvl = pulse_ofs < width_act;
      trig_evt  = tsrc_pat ? pat_start : bit_tick;
      next_aux_q  = aux_q;
      next_trig_q = 1'b1;
      // Bit is held after its read; the FIFO head already shows the next one
      if (fifo_rd_ready && fifo_rd_valid) begin
         nrz_bit = fifo_rd_data;
      end else begin
         nrz_bit = cur_bit;
      end
      next_cur_bit = nrz_bit;
      // RZ bit holds only the first half of each bit cell
      rz_bit = nrz_bit && (bit_cnt >= delay_act) &&
               (bit_cnt < delay_act + (bit_act >> 1));
      if (!gen_en) begin
         next_aux_q = 1'b0;
      end else begin
         case (mode)
            aopg_pkg::AOPG_MODE_PULSE: next_aux_q = pulse_lvl ^ pol_inv;
            aopg_pkg::AOPG_MODE_NRZ:   next_aux_q = nrz_bit ^ pol_inv;
            aopg_pkg::AOPG_MODE_RZ:    next_aux_q = rz_bit ^ pol_inv;
            aopg_pkg::AOPG_MODE_CLOCK: next_aux_q = clk_tog;
            aopg_pkg::AOPG_MODE_TRIG:  next_aux_q = ~trig_evt;
            default:                   next_aux_q = 1'b0;
         endcase
         next_trig_q = ~trig_evt;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aux_q   <= 1'b0;
         trig_q  <= 1'b1;
         cur_bit <= 1'b0;
      end else begin
         aux_q   <= next_aux_q;
         trig_q  <= next_trig_q;
         cur_bit <= next_cur_bit;
      end
   end

   always_comb begin
      aux_out  = aux_q;
      trig_out = trig_q;
   end
endmodule : aopg_gen

// ===== test/aopg_gen_properties.sv
// Checker for the auxiliary output pattern generator, bound to aopg_gen.
// Assumes software sets things up while the generator is disabled.
`timescale 1ns/100ps
`include "aopg_defines.svh"
module aopg_gen_properties (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic [3:0]  reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic        aux_in,
   input wire logic        aux_out,
   input wire logic        trig_out
);
   logic [7:0]   ctrl;
   logic [31:0]  per_reg, wid_reg, bit_reg, run, per, gap;
   logic [31:0]  pcl, wcl, bcl, plen;
   logic [15:0]  age;
   logic [126:0] hist;
   logic         aux_q, act_q, trig_q;
   wire          act     = aux_out ^ ctrl[3];
   wire          m_pulse = ctrl[7] && ctrl[2:0] == aopg_pkg::AOPG_MODE_PULSE;
   wire          m_nrz   = ctrl[7] && ctrl[2:0] == aopg_pkg::AOPG_MODE_NRZ;
   wire          m_rz    = ctrl[7] && ctrl[2:0] == aopg_pkg::AOPG_MODE_RZ;
   wire          m_clk   = ctrl[7] && ctrl[2:0] == aopg_pkg::AOPG_MODE_CLOCK;
   wire          m_trig  = ctrl[7] && ctrl[2:0] == aopg_pkg::AOPG_MODE_TRIG;
   ////////////////////////////////////////////////////////////////////////////
   // Shadow of the settings; age gates checks until old settings drained
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl    <= 8'h00;
         per_reg <= `AOPG_RST_PERIOD;
         wid_reg <= `AOPG_RST_WIDTH;
         bit_reg <= `AOPG_RST_BITTIME;
         age     <= 16'h0000;
      end else begin
         age <= reg_wr_in ? 16'h0000 : age + {15'h0000, age != 16'hffff};
         if (reg_wr_in && reg_addr_in == `AOPG_REG_CTRL) ctrl <= reg_wdata_in[7:0];
         if (reg_wr_in && reg_addr_in == `AOPG_REG_PERIOD) per_reg <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `AOPG_REG_WIDTH) wid_reg <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `AOPG_REG_BITTIME) bit_reg <= reg_wdata_in;
      end
   end
   // Run lengths; unknown until the first edge, which only keeps checks idle
   always_ff @(posedge clk_in) begin
      aux_q  <= aux_out;
      act_q  <= act;
      trig_q <= trig_out;
      hist   <= {hist[125:0], aux_out};
      run    <= (aux_out != aux_q) ? 32'h1 : run + 32'h1;
      per    <= (act && !act_q) ? 32'h1 : per + 32'h1;
      gap    <= (!trig_out && trig_q) ? 32'h1 : gap + 32'h1;
   end
   always_comb begin
      pcl = (per_reg < 32'h2) ? 32'h2 : per_reg;
      wcl = (wid_reg < 32'h2) ? 32'h2 : (wid_reg > pcl - 32'h2) ? pcl - 32'h2 : wid_reg;
      bcl = (m_rz && bit_reg < 32'h2) ? 32'h2 : (bit_reg == 32'h0) ? 32'h1 : bit_reg;
      case (ctrl[6:5])
         2'd0: plen = 32'd127;
         2'd1: plen = 32'd1023;
         2'd2: plen = 32'd2047;
         default: plen = 32'd32767;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_pulse_width: assert property (
      m_pulse && !act && act_q && age > run + 32'h10 |-> run == wcl)
      else $error("pulse active time differs from clamped width");
   a_pulse_period: assert property (
      m_pulse && act && !act_q && age > per + 32'h10 |-> per == pcl)
      else $error("pulse repeat time differs from period");
   a_nrz_bits: assert property (
      m_nrz && aux_out != aux_q && age > run + 32'h10 |-> run % bcl == 32'h0)
      else $error("stream level changed inside a bit");
   a_nrz_repeat: assert property (
      m_nrz && ctrl[6:5] == 2'd0 && bcl == 32'h1 && age > 16'd400 |-> aux_out == hist[126])
      else $error("shortest pattern does not repeat after 127 bits");
   a_rz_return: assert property (
      m_rz && !act && act_q && age > run + 32'h10 |-> run < bcl)
      else $error("return to zero stream held a mark for a whole bit");
   a_trig_spacing: assert property (
      m_trig && $fell(trig_out) && age > gap + 32'h10 |-> gap == (ctrl[4] ? bcl * plen : bcl))
      else $error("trigger spacing wrong for the chosen source");
   a_trig_pulse: assert property (
      $fell(trig_out) && (ctrl[4] || bcl != 32'h1) |=> trig_out)
      else $error("trigger pulse longer than one cycle");
   a_clock_toggle: assert property (m_clk && age > 16'd8 |-> aux_out != aux_q)
      else $error("clock output missed a toggle");
   c_pulse: cover property (m_pulse && act && !act_q && age > 16'd64);
   c_trig: cover property (m_trig && $fell(trig_out));
   c_nrz: cover property (m_nrz && age > 16'd400);
endmodule : aopg_gen_properties

bind aopg_gen aopg_gen_properties u_props (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .aux_in(aux_in), .aux_out(aux_out),
   .trig_out(trig_out)
);

// ===== test/aopg_far_model.sv
// Far-side device under test: counts edges and high time it receives.
// Assumes the generator's clock; also feeds junk into the spare input.
`timescale 1ns/100ps
module aopg_far_model (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Observed lines
   input  wire logic        sig_in,
   input  wire logic        trig_in,
   // Results
   output logic             noise_out,
   output logic [31:0]      rises_out,
   output logic [31:0]      highs_out,
   output logic [31:0]      falls_out
);
   logic sig_q;
   logic trig_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sig_q     <= 1'b0;
         trig_q    <= 1'b1;
         noise_out <= 1'b0;
         rises_out <= 32'h0;
         highs_out <= 32'h0;
         falls_out <= 32'h0;
      end else begin
         sig_q     <= sig_in;
         trig_q    <= trig_in;
         noise_out <= ~noise_out ^ rises_out[1];
         rises_out <= rises_out + {31'h0, sig_in & ~sig_q};
         highs_out <= highs_out + {31'h0, sig_in};
         falls_out <= falls_out + {31'h0, trig_q & ~trig_in};
      end
   end
endmodule : aopg_far_model

// ===== test/test_aopg_gen.sv
// Testbench for the auxiliary output pattern generator.
// Assumes the checker is bound in and the far model sits on the outputs.
`timescale 1ns/100ps
`include "aopg_defines.svh"
module test_aopg_gen;
   logic        clk_in       = 1'b0;
   logic        rst_n_in     = 1'b1;
   logic [3:0]  reg_addr_in  = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0;
   logic        reg_wr_in    = 1'b0;
   logic        reg_rd_in    = 1'b0;
   logic [31:0] reg_rdata_out, rises, highs, falls, dr, dh, df, rd;
   logic        aux_in, aux_out, trig_out;
   logic [31:0] rst_vals [6] = '{32'h0, `AOPG_RST_PERIOD, `AOPG_RST_WIDTH, 32'h0,
                                 `AOPG_RST_BITTIME, 32'h2};
   int          n_errors  = 0;
   int          tests_run = 0;

   always #2.5 clk_in = ~clk_in;

   aopg_gen dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .aux_in(aux_in), .aux_out(aux_out),
      .trig_out(trig_out));
   aopg_far_model u_far (.clk_in(clk_in), .rst_n_in(rst_n_in), .sig_in(aux_out),
      .trig_in(trig_out), .noise_out(aux_in), .rises_out(rises), .highs_out(highs),
      .falls_out(falls));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic check_near(input logic [31:0] got, exp, tol);
      tests_run++;
      if (((got + tol >= exp) && (got <= exp + tol)) !== 1'b1) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_near
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_in);
      reg_wr_in    <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [3:0] a);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_in);
      reg_rd_in   <= 1'b0;
      @(negedge clk_in);
      rd = reg_rdata_out;
   endtask : reg_read
   task automatic read_check(input logic [3:0] a, input logic [31:0] e);
      reg_read(a);
      check(rd, e);
   endtask : read_check
   // Settings go in while disabled so they apply at once
   task automatic setup(input logic [2:0] m, input logic p, t, input logic [1:0] l,
                        input logic [31:0] per, wid, dly, bt);
      reg_write(`AOPG_REG_CTRL, {24'h0, 1'b0, l, t, p, m});
      reg_write(`AOPG_REG_PERIOD, per);
      reg_write(`AOPG_REG_WIDTH, wid);
      reg_write(`AOPG_REG_DELAY, dly);
      reg_write(`AOPG_REG_BITTIME, bt);
      reg_write(`AOPG_REG_CTRL, {24'h0, 1'b1, l, t, p, m});
      repeat (40) @(posedge clk_in);
   endtask : setup
   task automatic measure(input int n);
      logic [31:0] r0, h0, f0;
      r0 = rises;
      h0 = highs;
      f0 = falls;
      repeat (n) @(posedge clk_in);
      dr = rises - r0;
      dh = highs - h0;
      df = falls - f0;
   endtask : measure
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #150000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      rst_n_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      foreach (rst_vals[i]) read_check(i[3:0], rst_vals[i]);
      reg_write(4'hf, 32'hffff_ffff);
      read_check(4'hf, 32'h0);
      setup(aopg_pkg::AOPG_MODE_CLOCK, 1'b0, 1'b0, 2'd0, 4, 2, 0, 1);
      measure(100);
      check_near(dr, 50, 1);
      setup(aopg_pkg::AOPG_MODE_PULSE, 1'b0, 1'b0, 2'd0, 10, 3, 2, 1);
      measure(200);
      check_near(dr, 20, 1);
      check_near(dh, 60, 3);
      setup(aopg_pkg::AOPG_MODE_PULSE, 1'b1, 1'b0, 2'd0, 10, 3, 8, 1);
      measure(200);
      check_near(dh, 140, 3);
      setup(aopg_pkg::AOPG_MODE_PULSE, 1'b0, 1'b0, 2'd0, 10, 30, 0, 1);
      measure(200);
      check_near(dh, 160, 8);
      setup(aopg_pkg::AOPG_MODE_PULSE, 1'b0, 1'b0, 2'd0, 4, 2, 2, 1);
      measure(200);
      check_near(dr, 50, 1);
      for (int l = 0; l < 4; l++) begin
         setup(aopg_pkg::AOPG_MODE_NRZ, l[1], l[0], l[1:0], 4, 2, 0, 1);
         measure(500);
         check({31'h0, dr != 32'h0}, 32'h1);
         reg_read(`AOPG_REG_PATTERN);
         check({31'h0, rd != 32'h0}, 32'h1);
         check({rd[31:15], 15'h0}, 32'h0);
      end
      setup(aopg_pkg::AOPG_MODE_NRZ, 1'b1, 1'b0, 2'd0, 4, 2, 0, 3);
      measure(400);
      check({31'h0, dr != 32'h0}, 32'h1);
      setup(aopg_pkg::AOPG_MODE_RZ, 1'b0, 1'b1, 2'd0, 4, 2, 0, 2);
      measure(400);
      check({31'h0, dr != 32'h0}, 32'h1);
      setup(aopg_pkg::AOPG_MODE_RZ, 1'b1, 1'b0, 2'd2, 4, 2, 0, 4);
      measure(400);
      check({31'h0, dr != 32'h0}, 32'h1);
      setup(aopg_pkg::AOPG_MODE_TRIG, 1'b0, 1'b0, 2'd0, 4, 2, 0, 5);
      measure(200);
      check_near(df, 40, 1);
      setup(aopg_pkg::AOPG_MODE_TRIG, 1'b0, 1'b1, 2'd0, 4, 2, 0, 1);
      measure(1270);
      check_near(df, 10, 1);
      report_and_stop();
   end
endmodule : test_aopg_gen
